// ==== dipi_pkg.sv ====
// constants and types for the digital input process image block
// Operation
// - multi-byte values little-endian, low byte at the lower address
// - one bit per input channel showing its present signal state
// - diagnostic modules add one fault flag per channel
// - single-channel diagnostic byte: state bit 0, fault bit 1
// - two-channel byte: channel 1 bit 0, channel 2 bit 1
// - two-channel diagnostic byte: states bits 0-1, faults bits 2-3
// - latching module sets channel fault flag as soon as fault appears
// - latched channel stays inactive until fault gone and acknowledge set
// - latching output byte: acknowledges bits 2-3, bits 0-1 zero
// - four-channel byte: channels 1 to 4 in bits 0 to 3
// - eight-channel byte: channel n in bit n minus one
package dipi_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;

  // word addresses of the image words
  localparam logic [ADDR_W-1:0] ADDR_W0 = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_W1 = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_W2 = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_OUT = 3'h3;

  // field positions inside an image byte
  localparam int POS_ST1 = 0;
  localparam int POS_ST2 = 1;
  localparam int POS_FLT1_1CH = 1;
  localparam int POS_FLT1 = 2;
  localparam int POS_FLT2 = 3;
  localparam int POS_ACK1 = 2;
  localparam int POS_ACK2 = 3;

  // byte lanes of a 16-bit word, low byte at the lower byte address
  localparam int LANE_LO = 0;
  localparam int LANE_HI = 8;

  localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;
  localparam logic [1:0] ACK_RST = 2'h0;
  localparam logic [1:0] LATCH_RST = 2'h0;
  localparam int SYNC_STAGES = 2;

  // field pins of every module personality
  typedef struct packed {
    logic st_1d;
    logic flt_1d;
    logic [1:0] st_2;
    logic [1:0] st_2d;
    logic [1:0] flt_2d;
    logic [1:0] st_lat;
    logic [1:0] flt_lat;
    logic [3:0] st_4;
    logic [7:0] st_8;
  } dipi_field_t;

  localparam int FIELD_W = $bits(dipi_field_t);

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } dipi_bus_t;

endpackage

// ==== dipi_sync.sv ====
// two-stage synchroniser for field pins
`timescale 1ns/100ps
module dipi_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ==== dipi_top.sv ====
// digital input process image: field pins packed into image words
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/100ps
module dipi_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire dipi_pkg::dipi_field_t field_in,
  input wire dipi_pkg::dipi_bus_t bus,
  output logic [dipi_pkg::DATA_W-1:0] rdata_q
);
  import dipi_pkg::*;

  dipi_field_t in_s;
  logic [FIELD_W-1:0] in_s_raw;
  logic [1:0] ack_q;
  logic [1:0] lat_q;
  logic [1:0] lat_d;
  logic [7:0] b_1d;
  logic [7:0] b_2;
  logic [7:0] b_2d;
  logic [7:0] b_lat;
  logic [7:0] b_4;
  logic [7:0] b_8;
  logic [7:0] b_out;
  logic [DATA_W-1:0] word_d;

  // every field pin passes two flip-flops before the image reads it
  dipi_sync #(
    .W(FIELD_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(field_in),
    .q(in_s_raw)
  );

  assign in_s = dipi_field_t'(in_s_raw);

  // image bytes; every bit not named stays zero
  always_comb
  begin
    b_1d = 8'h00;
    b_1d[POS_ST1] = in_s.st_1d;
    b_1d[POS_FLT1_1CH] = in_s.flt_1d;
    b_2 = 8'h00;
    b_2[POS_ST2:POS_ST1] = in_s.st_2;
    b_2d = 8'h00;
    b_2d[POS_ST2:POS_ST1] = in_s.st_2d;
    b_2d[POS_FLT2:POS_FLT1] = in_s.flt_2d;
    b_lat = 8'h00;
    // a latched channel is held inactive
    b_lat[POS_ST2:POS_ST1] = in_s.st_lat & ~lat_q;
    b_lat[POS_FLT2:POS_FLT1] = lat_q;
    b_4 = {4'h0, in_s.st_4};
    b_8 = in_s.st_8;
    b_out = 8'h00;
    b_out[POS_ACK2:POS_ACK1] = ack_q;
  end

  // word select, low byte in the low lane
  always_comb
  begin
    word_d = RDATA_RST;
    case (bus.addr)
      ADDR_W0: word_d = {b_2, b_1d};
      ADDR_W1: word_d = {b_lat, b_2d};
      ADDR_W2: word_d = {b_8, b_4};
      ADDR_OUT: word_d = {8'h00, b_out};
      default: word_d = RDATA_RST;
    endcase
  end

  // read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= RDATA_RST;
    else if (bus.rd)
      rdata_q <= word_d;
    else
      rdata_q <= RDATA_RST;
  end

  // acknowledge bits of the output byte; bits 0-1 and above are dropped
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= ACK_RST;
    else if (bus.wr && bus.addr == ADDR_OUT)
      ack_q <= bus.wdata[LANE_LO+POS_ACK2:LANE_LO+POS_ACK1];
  end

  // fault latch: set on fault, set wins over acknowledge
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (in_s.flt_lat[i])
        lat_d[i] = 1'b1;
      else if (ack_q[i])
        lat_d[i] = 1'b0;
      else
        lat_d[i] = lat_q[i];
    end
  end

  // one fault flag per channel of the latching module
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lat_q <= LATCH_RST;
    else
      lat_q <= lat_d;
  end

  a_read_8ch: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == ADDR_W2 |=> rdata_q[15:8] == $past(in_s.st_8))
    else $error("eight-channel byte mismatch");

  a_read_4ch: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == ADDR_W2
    |=> rdata_q[7:0] == {4'h0, $past(in_s.st_4)})
    else $error("four-channel byte mismatch");

  a_read_1ch_diag: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == ADDR_W0
    |=> rdata_q[1:0] == {$past(in_s.flt_1d), $past(in_s.st_1d)}
        && rdata_q[7:2] == 6'h00)
    else $error("single-channel diagnostic byte mismatch");

  a_read_2ch: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == ADDR_W0
    |=> rdata_q[15:8] == {6'h00, $past(in_s.st_2)})
    else $error("two-channel byte mismatch");

  a_read_2ch_diag: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == ADDR_W1
    |=> rdata_q[7:0] == {4'h0, $past(in_s.flt_2d), $past(in_s.st_2d)})
    else $error("two-channel diagnostic byte mismatch");

  a_latch_sets: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_s.flt_lat[0] |=> lat_q[0])
    else $error("fault latch did not set");

  a_latch_holds: assert property (
    @(posedge clk) disable iff (!rst_n)
    lat_q[1] && !ack_q[1] |=> lat_q[1])
    else $error("fault latch released without acknowledge");

  a_latch_clears: assert property (
    @(posedge clk) disable iff (!rst_n)
    lat_q[0] && ack_q[0] && !in_s.flt_lat[0] |=> !lat_q[0])
    else $error("acknowledged latch not released");

  a_latch_inactive: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == ADDR_W1 && lat_q[0]
    |=> !rdata_q[8] && rdata_q[10])
    else $error("latched channel shown active");

  a_ack_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.wr && bus.addr == ADDR_OUT
    ##1 bus.rd && bus.addr == ADDR_OUT
    |=> rdata_q == {12'h000, $past(bus.wdata[3:2], 2), 2'h0})
    else $error("acknowledge byte readback wrong");

  a_idle_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    !bus.rd |=> rdata_q == RDATA_RST)
    else $error("read data outside read cycle");

  // fault latch: both channels and the priority of a fault
  a_latch_sets_ch2: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_s.flt_lat[1] |=> lat_q[1])
    else $error("second fault latch did not set");

  a_latch_holds_ch1: assert property (
    @(posedge clk) disable iff (!rst_n)
    lat_q[0] && !ack_q[0] |=> lat_q[0])
    else $error("first fault latch released without acknowledge");

  a_latch_clears_ch2: assert property (
    @(posedge clk) disable iff (!rst_n)
    lat_q[1] && ack_q[1] && !in_s.flt_lat[1] |=> !lat_q[1])
    else $error("acknowledged second latch not released");

  a_fault_wins_ch1: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_s.flt_lat[0] && ack_q[0] |=> lat_q[0])
    else $error("acknowledge cleared first latch under fault");

  a_fault_wins_ch2: assert property (
    @(posedge clk) disable iff (!rst_n)
    in_s.flt_lat[1] && ack_q[1] |=> lat_q[1])
    else $error("acknowledge cleared second latch under fault");

  a_no_spurious_ch1: assert property (
    @(posedge clk) disable iff (!rst_n)
    !lat_q[0] && !in_s.flt_lat[0] |=> !lat_q[0])
    else $error("first latch set without fault");

  a_no_spurious_ch2: assert property (
    @(posedge clk) disable iff (!rst_n)
    !lat_q[1] && !in_s.flt_lat[1] |=> !lat_q[1])
    else $error("second latch set without fault");

  a_latch_inactive_ch2: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == ADDR_W1 && lat_q[1]
    |=> !rdata_q[9] && rdata_q[11])
    else $error("second latched channel shown active");

  a_latch_active_ch1: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == ADDR_W1 && !lat_q[0]
    |=> rdata_q[8] == $past(in_s.st_lat[0]))
    else $error("free first channel state not shown");

  a_latch_active_ch2: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == ADDR_W1 && !lat_q[1]
    |=> rdata_q[9] == $past(in_s.st_lat[1]))
    else $error("free second channel state not shown");

  a_latch_byte: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == ADDR_W1
    |=> rdata_q[15:12] == 4'h0 && rdata_q[11:10] == $past(lat_q))
    else $error("latching byte flags or padding wrong");

  a_latch_masks: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == ADDR_W1
    |=> rdata_q[9:8] == $past(in_s.st_lat & ~lat_q))
    else $error("latched channels not masked");

  // fault flags, acknowledge byte and unmapped words
  a_read_1ch_fault: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == ADDR_W0 |=> rdata_q[1] == $past(in_s.flt_1d))
    else $error("single-channel fault flag not shown");

  a_read_2ch_faults: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == ADDR_W1 |=> rdata_q[3:2] == $past(in_s.flt_2d))
    else $error("two-channel fault flags not shown");

  a_ack_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.wr && bus.addr == ADDR_OUT |=> ack_q == $past(bus.wdata[3:2]))
    else $error("acknowledge bits not taken from write");

  a_ack_holds: assert property (
    @(posedge clk) disable iff (!rst_n)
    !(bus.wr && bus.addr == ADDR_OUT) |=> $stable(ack_q))
    else $error("acknowledge bits changed without write");

  a_image_no_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.wr && bus.addr != ADDR_OUT |=> $stable(ack_q))
    else $error("write to image word reached acknowledge bits");

  a_read_out_byte: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == ADDR_OUT
    |=> rdata_q == {12'h000, $past(ack_q), 2'h0})
    else $error("output byte readback wrong");

  a_read_unmapped: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr > ADDR_OUT |=> rdata_q == RDATA_RST)
    else $error("unmapped word not zero");

  // pins reach the image after two flip-flops
  a_sync_two_flops: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $past(rst_n, 2) |-> in_s_raw == $past(field_in, 2))
    else $error("synchronised pins do not follow field pins");

  c_latch_cycle: cover property (
    @(posedge clk) disable iff (!rst_n)
    lat_q[0] ##1 !lat_q[0]);

  c_ack_write: cover property (
    @(posedge clk) disable iff (!rst_n)
    bus.wr && bus.addr == ADDR_OUT);

  c_read_8ch: cover property (
    @(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == ADDR_W2 && in_s.st_8 == 8'hFF);

  c_fault_over_ack: cover property (
    @(posedge clk) disable iff (!rst_n)
    in_s.flt_lat[0] && ack_q[0] && lat_q[0]);

  c_ack_readback: cover property (
    @(posedge clk) disable iff (!rst_n)
    bus.wr && bus.addr == ADDR_OUT ##1 bus.rd && bus.addr == ADDR_OUT);

endmodule

// ==== dipi_ctrl_bfm.sv ====
// controller model: issues image bus reads and writes
`timescale 1ns/100ps
module dipi_ctrl_bfm (
  input wire logic clk,
  output dipi_pkg::dipi_bus_t bus
);
  import dipi_pkg::*;
  initial bus = '0;
  // one-cycle strobe, held until the sampling edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask
  // write then read with no gap between the strobes
  task automatic wr_rd(input logic [ADDR_W-1:0] wa,
    input logic [DATA_W-1:0] d, input logic [ADDR_W-1:0] ra);
    @(posedge clk);
    bus <= '{addr: wa, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: ra, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask
endmodule

// ==== dipi_top_test.sv ====
// self-checking bench for the input process image block
`timescale 1ns/100ps
module dipi_top_test;
  import dipi_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  dipi_field_t fld = '0;
  dipi_bus_t bus;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] exp_q[$];
  logic [1:0] lat_e = 2'h0;
  logic [1:0] ack_e = 2'h0;
  logic pend = 1'b0;
  int num_errors = 0;
  int tests_run = 0;
  dipi_top i_dipi_top (.clk(clk), .rst_n(rst_n), .field_in(fld), .bus(bus),
    .rdata_q(rdata_q));
  dipi_ctrl_bfm i_dipi_ctrl_bfm (.clk(clk), .bus(bus));
  initial forever #5 clk = ~clk;
  function automatic logic [DATA_W-1:0] img(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_W0: img = {6'h0, fld.st_2, 6'h0, fld.flt_1d, fld.st_1d};
      ADDR_W1: img = {4'h0, lat_e, fld.st_lat & ~lat_e, 4'h0, fld.flt_2d,
        fld.st_2d};
      ADDR_W2: img = {fld.st_8, 4'h0, fld.st_4};
      ADDR_OUT: img = {12'h0, ack_e, 2'h0};
      default: img = 16'h0000;
    endcase
  endfunction
  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] e);
    tests_run++;
    if (got !== e)
    begin
      num_errors++;
      $display("BAD %0t read %h expected %h", $time, got, e);
    end
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a);
    exp_q.push_back(img(a));
    i_dipi_ctrl_bfm.rd(a);
  endtask
  task automatic ack_chk(input logic [1:0] ack);
    ack_e = ack;
    exp_q.push_back(img(ADDR_OUT));
    i_dipi_ctrl_bfm.wr_rd(ADDR_OUT, {12'($urandom()), ack, 2'h0}, ADDR_OUT);
  endtask
  task automatic end_sim;
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // read data stand only in the cycle after the strobe
  always @(negedge clk)
  begin
    if (pend)
      cmp(rdata_q, exp_q.pop_front());
    else
      cmp(rdata_q, 16'h0000);
    pend = bus.rd;
  end
  initial
  begin
    #100us;
    num_errors++;
    end_sim();
  end
  initial
  begin
    void'($urandom(70288));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk);
      // latching faults stay off here
      fld <= dipi_field_t'(24'($urandom()) & 24'hFFCFFF);
      repeat (3) @(posedge clk);
      for (int a = 0; a < 8; a++)
        rd_chk(3'(a));
    end
    i_dipi_ctrl_bfm.wr(ADDR_W0, 16'hFFFF);
    rd_chk(ADDR_W0);
    @(posedge clk);
    // both latching channels see a fault
    fld <= dipi_field_t'(fld | 24'h00F000);
    repeat (4) @(posedge clk);
    lat_e = 2'h3;
    rd_chk(ADDR_W1);
    fld.flt_lat <= 2'h1;
    repeat (4) @(posedge clk);
    rd_chk(ADDR_W1);
    ack_chk(2'h3);
    lat_e = 2'h1;
    rd_chk(ADDR_W1);
    fld.flt_lat <= 2'h0;
    repeat (4) @(posedge clk);
    lat_e = 2'h0;
    rd_chk(ADDR_W1);
    ack_chk(2'h0);
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule
